// ===== wdt_top.sv
// Watchdog timer with its AXI4-Lite register slave and status flags.
`timescale 1ns/10ps
module wdt_top
  import wdt_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic [1:0]             o_bresp,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  input  wire logic [1:0]        i_timer_enable_config_field_cfg,
  input  wire logic              i_lfosc_tick,
  input  wire logic              i_alt_tick,
  input  wire logic              i_clear_instr,
  input  wire logic              i_sleep_enter,
  input  wire logic              i_wake_req,
  output logic                   o_sys_reset,
  output logic                   o_wake,
  output logic                   o_asleep,
  output logic                   o_active,
  output logic                   o_irq
);
  wdt_ctrl_type           ctrl;
  wdt_flags_type          flags;
  logic [EV_W-1:0]        ev;
  logic [EV_W-1:0]        mask;
  logic                   aw_have;
  logic                   w_have;
  logic [ADDR_W-1:0]      waddr;
  logic [31:0]            wdata;
  logic [3:0]             wstrb;
  logic                   active;
  logic                   expire;
  logic [CW-1:0]          count;
  wdt_mode_type           mode;

  // Write channel: address and data are taken in either order.
  wire take_aw = i_awvalid && o_awready;
  wire take_w  = i_wvalid && o_wready;
  wire do_wr   = aw_have && w_have && !o_bvalid;
  wire next_aw_have = do_wr ? 1'b0 : (aw_have || take_aw);
  wire next_w_have  = do_wr ? 1'b0 : (w_have || take_w);
  wire next_bvalid  = do_wr || (o_bvalid && !i_bready);

  wire [9:0] wword  = waddr[ADDR_W-1:2];
  wire hit_ctrl     = wword == CTRL_OFF[ADDR_W-1:2];
  wire hit_flag     = wword == FLAG_OFF[ADDR_W-1:2];
  wire hit_evt      = wword == EVT_OFF[ADDR_W-1:2];
  wire hit_mask     = wword == MASK_OFF[ADDR_W-1:2];
  wire wr_hit       = hit_ctrl || hit_flag || hit_evt || hit_mask;
  wire wr_ctrl      = do_wr && hit_ctrl;
  wire wr_flag      = do_wr && hit_flag && wstrb[0];
  wire wr_evt       = do_wr && hit_evt && wstrb[0];
  wire wr_mask      = do_wr && hit_mask && wstrb[0];

  // Read channel: one read at a time, data from a register.
  wire take_ar     = i_arvalid && o_arready;
  wire next_rvalid = take_ar || (o_rvalid && !i_rready);
  wire [9:0] rword = i_araddr[ADDR_W-1:2];
  wire rd_ctrl     = rword == CTRL_OFF[ADDR_W-1:2];
  wire rd_flag     = rword == FLAG_OFF[ADDR_W-1:2];
  wire rd_evt      = rword == EVT_OFF[ADDR_W-1:2];
  wire rd_mask     = rword == MASK_OFF[ADDR_W-1:2];
  wire rd_hit      = rd_ctrl || rd_flag || rd_evt || rd_mask;
  wire [31:0] rd_word =
    rd_ctrl ? {24'h000000, wdt_ctrl_word(ctrl)} :
    rd_flag ? {29'h0, flags} :
    rd_evt  ? {30'h0, ev} :
    rd_mask ? {30'h0, mask} : 32'h00000000;

  // Sleep handling and watchdog events.
  wire sleep_go    = i_sleep_enter && !o_asleep;
  wire wake_go     = o_asleep && (i_wake_req || expire);
  wire wdt_rst     = expire && !o_asleep;
  wire cnt_clear   = wr_ctrl || i_clear_instr || sleep_go || wake_go
                     || wdt_rst;
  wire tick        = ctrl.cs ? i_alt_tick : i_lfosc_tick;
  wire [EV_W-1:0] ev_set = {expire && o_asleep, wdt_rst};
  wire [EV_W-1:0] ev_clr = wr_evt ? wdata[EV_W-1:0] : '0;
  // A new event wins over a write-one-to-clear in the same cycle.
  wire [EV_W-1:0] next_ev = (ev & ~ev_clr) | ev_set;

  assign mode = wdt_mode_type'(i_timer_enable_config_field_cfg);

  always_comb begin
    case (mode)
      MODE_ON:      active = 1'b1;
      MODE_NOSLEEP: active = !o_asleep;
      MODE_SW:      active = ctrl.software_watch_enable;
      MODE_OFF:     active = 1'b0;
      default:      active = 1'b0;
    endcase
  end

  wdt_count #(
    .W (CW)
  ) u_count (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_clear  (cnt_clear),
    .i_run    (active),
    .i_tick   (tick),
    .i_ps     (ctrl.ps),
    .o_expire (expire),
    .o_count  (count)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_have   <= 1'b0;
      w_have    <= 1'b0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OK;
      waddr     <= '0;
      wdata     <= 32'h00000000;
      wstrb     <= 4'h0;
    end else begin
      aw_have   <= next_aw_have;
      w_have    <= next_w_have;
      o_awready <= !next_aw_have && !next_bvalid;
      o_wready  <= !next_w_have && !next_bvalid;
      o_bvalid  <= next_bvalid;
      if (do_wr) begin
        o_bresp <= wr_hit ? RESP_OK : RESP_ERR;
      end
      if (take_aw) begin
        waddr <= i_awaddr;
      end
      if (take_w) begin
        wdata <= i_wdata;
        wstrb <= i_wstrb;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= RESP_OK;
    end else begin
      o_arready <= !next_rvalid;
      o_rvalid  <= next_rvalid;
      if (take_ar) begin
        o_rdata <= rd_word;
        o_rresp <= rd_hit ? RESP_OK : RESP_ERR;
      end
    end
  end

  // A watchdog reset is a reset too, so it reloads the control word.
  always_ff @(posedge i_clk) begin
    if (i_rst || wdt_rst) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl && wstrb[0]) begin
      ctrl.cs  <= wdata[CS_BIT];
      ctrl.ps  <= wdata[PS_MSB:PS_LSB];
      ctrl.software_watch_enable <= wdata[SEN_BIT];
    end
  end

  // Hardware updates come last so they win over a software write.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flags <= FLAGS_RESET;
    end else begin
      if (wr_flag) begin
        flags <= wdt_flags_type'(wdata[2:0]);
      end
      if (sleep_go) begin
        flags.pd_n <= 1'b0;
        flags.to_n <= 1'b1;
      end
      if (expire) begin
        flags.watch_reset_cause_flag_n <= 1'b0;
      end
      if (wake_go && expire) begin
        flags.to_n <= 1'b0;
        flags.pd_n <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ev          <= '0;
      mask        <= '0;
      o_irq       <= 1'b0;
      o_asleep    <= 1'b0;
      o_sys_reset <= 1'b0;
      o_wake      <= 1'b0;
      o_active    <= 1'b0;
    end else begin
      ev          <= next_ev;
      o_irq       <= |(next_ev & (wr_mask ? wdata[EV_W-1:0] : mask));
      if (wr_mask) begin
        mask <= wdata[EV_W-1:0];
      end
      o_asleep    <= sleep_go || (o_asleep && !wake_go);
      o_sys_reset <= wdt_rst;
      o_wake      <= wake_go;
      o_active    <= active;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_sleep_go;
    i_sleep_enter && !o_asleep;
  endsequence
  sequence s_awake_expire;
    expire && !o_asleep;
  endsequence
  sequence s_sleep_expire;
    expire && o_asleep;
  endsequence

  reset_on_timeout_a: assert property (s_awake_expire |=> o_sys_reset ##1 !o_sys_reset)
    else $error("no one-cycle system reset on time-out");
  sleep_wake_a: assert property (s_sleep_expire |=> o_wake && !o_sys_reset
    && !o_asleep && !flags.to_n && !flags.pd_n)
    else $error("sleep time-out did not wake cleanly");
  cause_flag_a: assert property (expire |=> !flags.watch_reset_cause_flag_n)
    else $error("reset-cause flag not cleared");
  sleep_flags_a: assert property (s_sleep_go ##0 !expire |=> o_asleep
    && !flags.pd_n && flags.to_n && count == '0)
    else $error("sleep entry flags or clear wrong");
  mode_on_a: assert property (i_timer_enable_config_field_cfg == 2'b11 |-> active)
    else $error("always-on mode inactive");
  mode_nosleep_a: assert property (i_timer_enable_config_field_cfg == 2'b10 |-> active == !o_asleep)
    else $error("awake-only mode wrong");
  mode_sw_a: assert property (i_timer_enable_config_field_cfg == 2'b01 |-> active == ctrl.software_watch_enable)
    else $error("software mode does not follow enable");
  mode_off_a: assert property (i_timer_enable_config_field_cfg == 2'b00 |-> !active && !expire)
    else $error("off mode still active");
  ctrl_write_clear_a: assert property (wr_ctrl |=> count == '0 && !expire)
    else $error("control write did not clear counter");
  prescale_reset_a: assert property (o_sys_reset |-> ctrl.ps == PS_RESET && !ctrl.software_watch_enable)
    else $error("prescale not reloaded after watchdog reset");
  bit6_read_a: assert property (take_ar && rd_ctrl |=> o_rvalid && !o_rdata[6])
    else $error("control bit 6 reads nonzero");

  // An answer stands until it is taken, and nothing new is taken meanwhile.
  sequence s_write_done;
    o_bvalid && i_bready;
  endsequence
  sequence s_read_done;
    o_rvalid && i_rready;
  endsequence
  sequence s_wake_pulse;
    o_asleep && i_wake_req;
  endsequence

  bvalid_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)
    && $stable(o_rresp))
    else $error("read data dropped early");
  write_done_a: assert property (s_write_done |=> !o_bvalid)
    else $error("write response repeated");
  read_done_a: assert property (s_read_done |=> !o_rvalid)
    else $error("read data repeated");
  write_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  read_busy_a: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while data pending");
  unmapped_err_a: assert property (do_wr && !wr_hit |=> o_bvalid && o_bresp == RESP_ERR)
    else $error("unmapped write not refused");
  clear_instr_a: assert property (i_clear_instr |=> count == '0 && !expire)
    else $error("clear instruction did not clear counter");
  wake_clear_a: assert property (s_wake_pulse |=> count == '0 && o_wake)
    else $error("wake did not clear counter");
  lfosc_source_a: assert property (!ctrl.cs && active && !cnt_clear
    |=> (count != $past(count)) == $past(i_lfosc_tick))
    else $error("oscillator tick not counted alone");
  alt_source_a: assert property (ctrl.cs && active && !cnt_clear
    |=> (count != $past(count)) == $past(i_alt_tick))
    else $error("alternate tick not counted alone");
  idle_zero_a: assert property (!active |=> count == '0)
    else $error("idle counter not held at zero");
  irq_level_a: assert property (o_irq == |(ev & mask))
    else $error("interrupt level wrong");
  event_sticky_a: assert property (ev[0] && !(wr_evt && wdata[0]) |=> ev[0])
    else $error("event bit lost without clear");
  event_set_a: assert property (wdt_rst |=> ev[0] && o_sys_reset)
    else $error("time-out event not recorded");
  wake_event_a: assert property (s_sleep_expire |=> ev[1])
    else $error("wake event not recorded");
  wake_one_a: assert property (o_wake |=> !o_wake)
    else $error("wake pulse too long");
  stay_asleep_a: assert property (o_asleep && !i_wake_req && !expire |=> o_asleep)
    else $error("left sleep without a wake source");
  reserved_ps_a: assert property (ctrl.ps > PS_MAX && active && tick
    && count == CW'(31) && !cnt_clear |=> expire)
    else $error("reserved prescale not shortest");
  short_ratio_a: assert property (ctrl.ps <= PS_MAX && active && tick
    && count == CW'(31) && !cnt_clear |=> expire == (ctrl.ps == 5'h00))
    else $error("ratio does not follow prescale code");
  flags_write_a: assert property (wr_flag && !sleep_go && !expire
    |=> flags == $past(wdata[2:0]))
    else $error("flag write lost");
  sleep_restart_a: assert property (s_sleep_go ##0 mode == MODE_ON
    |=> count == '0 && o_active)
    else $error("always-on watchdog stopped in sleep");
  ctrl_load_a: assert property (wr_ctrl && wstrb[0] && !wdt_rst
    |=> wdt_ctrl_word(ctrl) == ($past(wdata[7:0]) & 8'hbf))
    else $error("control write not stored");
endmodule // wdt_top

// ===== wdt_pkg.sv
// Shared constants, field layouts and types of the watchdog block.
package wdt_pkg;
  localparam int          ADDR_W     = 12;
  localparam logic [11:0] CTRL_OFF   = 12'h80c;
  localparam logic [11:0] FLAG_OFF   = 12'h810;
  localparam logic [11:0] EVT_OFF    = 12'h814;
  localparam logic [11:0] MASK_OFF   = 12'h818;
  localparam int          CS_BIT     = 7;
  localparam int          PS_LSB     = 1;
  localparam int          PS_MSB     = 5;
  localparam int          SEN_BIT    = 0;
  localparam logic [4:0]  PS_RESET   = 5'h0b;
  localparam logic [4:0]  PS_MAX     = 5'h12;
  localparam logic [4:0]  RATIO_BASE = 5'h05;
  localparam int          CNT_W      = 24;
  localparam int          EV_RST     = 0;
  localparam int          EV_WAKE    = 1;
  localparam int          EV_W       = 2;
  localparam logic [1:0]  RESP_OK    = 2'h0;
  localparam logic [1:0]  RESP_ERR   = 2'h2;

  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_SW      = 2'b01,
    MODE_NOSLEEP = 2'b10,
    MODE_ON      = 2'b11
  } wdt_mode_type;

  typedef struct packed {
    logic       cs;
    logic [4:0] ps;
    logic       software_watch_enable;
  } wdt_ctrl_type;

  typedef struct packed {
    logic watch_reset_cause_flag_n;
    logic pd_n;
    logic to_n;
  } wdt_flags_type;

  localparam wdt_ctrl_type  CTRL_RESET  = '{cs: 1'b0, ps: PS_RESET, software_watch_enable: 1'b0};
  localparam wdt_flags_type FLAGS_RESET = 3'h7;

  // Reserved codes fall back to the shortest ratio.
  function automatic logic [CNT_W-1:0] wdt_limit(input logic [4:0] ps);
    logic [4:0] n;
    n = (ps > PS_MAX) ? 5'h00 : ps;
    wdt_limit = CNT_W'(1) << (n + RATIO_BASE);
  endfunction

  // Register image of the control word; bit 6 always reads zero.
  function automatic logic [7:0] wdt_ctrl_word(input wdt_ctrl_type c);
    wdt_ctrl_word = {c.cs, 1'b0, c.ps, c.software_watch_enable};
  endfunction
endpackage

// ===== wdt_count.sv
// Prescaled watchdog counter with a selectable time-out limit.
`timescale 1ns/10ps
module wdt_count
  import wdt_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_clear,
  input  wire logic         i_run,
  input  wire logic         i_tick,
  input  wire logic [4:0]   i_ps,
  output logic              o_expire,
  output logic [W-1:0]      o_count
);
  wire [W-1:0] limit = W'(wdt_limit(i_ps));
  wire         last  = (o_count + W'(1)) == limit;
  wire         step  = i_run && i_tick;

  // An idle watchdog holds zero, so enabling it always starts a full period.
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear || !i_run) begin
      o_count  <= '0;
      o_expire <= 1'b0;
    end else begin
      o_expire <= step && last;
      if (step) begin
        o_count <= last ? '0 : o_count + W'(1);
      end
    end
  end

  clear_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_clear |=> o_count == '0 && !o_expire)
    else $error("counter not cleared");
  expire_limit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_expire |-> $past(o_count) == $past(limit) - W'(1))
    else $error("expiry at wrong count");
endmodule // wdt_count

// ===== tb_top.sv
// Self-checking bench for the watchdog block and its register slave.
`timescale 1ns/10ps
module tb_top
  import wdt_pkg::*;
;
  logic        clk, rst, awv, wv, bre, arv, rre, lf, at, ci, se, wq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, v;
  logic [3:0]  ws;
  logic [1:0]  cfg, br, rr, r;
  logic        awr, wrdy, bv, arr, rv, srst, wk, slp, act, irq;
  int          n_errors, n_compared, n_rst, n_wk, i, n0;
  logic [4:0]  pss [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1f};
  int          lim [5] = '{32, 64, 128, 32, 32};

  wdt_top wdt_top_inst (.i_clk(clk), .i_rst(rst), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wd), .i_wstrb(ws),
    .o_bvalid(bv), .i_bready(bre), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
    .i_araddr(ara), .o_rvalid(rv), .i_rready(rre), .o_rdata(rd), .o_rresp(rr),
    .i_timer_enable_config_field_cfg(cfg), .i_lfosc_tick(lf), .i_alt_tick(at), .i_clear_instr(ci),
    .i_sleep_enter(se), .i_wake_req(wq), .o_sys_reset(srst), .o_wake(wk),
    .o_asleep(slp), .o_active(act), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulses are counted between edges so the count never races the edge update.
  always @(negedge clk) begin
    if (srst === 1'b1) n_rst++;
    if (wk === 1'b1) n_wk++;
  end

  task automatic report_and_stop;
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hang;
    n_errors++;
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Handshakes are judged between edges; ready is registered, so it holds to the edge.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    int   k;
    awa <= a;
    awv <= 1'b1;
    wd  <= {24'h0, d};
    wv  <= 1'b1;
    bre <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wrdy;
      tb = bre & bv;
      r  = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      // Ready stays up, so a following call never drives it twice in one step.
      if (tb) begin
        return;
      end
    end
    hang();
  endtask

  task automatic rdr(input logic [11:0] a);
    logic ta, tb;
    int   k;
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge clk);
      ta = arv & arr;
      tb = rre & rv;
      v  = rd;
      r  = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tb) begin
        return;
      end
    end
    hang();
  endtask

  task automatic tk(input logic alt, input int n);
    repeat (n) begin
      lf <= !alt;
      at <= alt;
      @(posedge clk);
      lf <= 1'b0;
      at <= 1'b0;
      @(posedge clk);
    end
  endtask

  // One-cycle strobes: bit 0 is the clear, bit 1 sleep entry and bit 2 the wake request.
  task automatic pulse(input logic [2:0] m);
    {wq, se, ci} <= m;
    @(posedge clk);
    {wq, se, ci} <= 3'b000;
    @(posedge clk);
  endtask

  // One tick short of the limit must stay quiet; the last tick must fire.
  task automatic expire(input logic alt, input int n);
    n0 = n_rst;
    tk(alt, n - 1);
    cyc(4);
    chk(n_rst - n0, 0);
    tk(alt, 1);
    cyc(3);
    chk(n_rst - n0, 1);
  endtask

  initial begin
    {rst, awv, wv, bre, arv, rre, lf, at, ci, se, wq} <= 11'h400;
    {awa, ara, wd, ws, cfg} <= {24'h0, 32'h0, 4'hf, 2'b01};
    cyc(12);
    rst <= 1'b0;
    cyc(2);
    rdr(CTRL_OFF);
    chk(v, 32'h16);
    rdr(FLAG_OFF);
    chk(v, 32'h7);
    rdr(MASK_OFF);
    chk(v, 32'h0);
    wr(12'h900, 8'h01);
    chk(r, RESP_ERR);
    rdr(12'h900);
    chk(r, RESP_ERR);
    chk(v, 32'h0);
    cfg <= 2'b00;
    wr(CTRL_OFF, 8'hff);
    rdr(CTRL_OFF);
    chk(v, 32'hbf);
    for (i = 0; i < 8; i++) begin
      cfg <= i[2:1];
      wr(CTRL_OFF, {7'h0b, i[0]});
      cyc(3);
      chk(act, i >= 3);
    end
    cfg <= 2'b01;
    for (i = 0; i < 5; i++) begin
      wr(CTRL_OFF, {2'b00, pss[i], 1'b1});
      expire(1'b0, lim[i]);
      rdr(CTRL_OFF);
      chk(v, 32'h16);
    end
    rdr(FLAG_OFF);
    chk(v, 32'h3);
    rdr(EVT_OFF);
    chk(v, 32'h1);
    chk(irq, 1'b0);
    wr(MASK_OFF, 8'h01);
    cyc(2);
    chk(irq, 1'b1);
    wr(EVT_OFF, 8'h01);
    cyc(2);
    chk(irq, 1'b0);
    wr(CTRL_OFF, 8'h81);
    tk(1'b0, 40);
    expire(1'b1, 32);
    wr(CTRL_OFF, 8'h01);
    n0 = n_rst;
    tk(1'b0, 20);
    pulse(3'b001);
    tk(1'b0, 20);
    chk(n_rst - n0, 0);
    wr(CTRL_OFF, 8'h01);
    expire(1'b0, 32);
    wr(FLAG_OFF, 8'h07);
    wr(EVT_OFF, 8'h03);
    cfg <= 2'b11;
    wr(CTRL_OFF, 8'h00);
    tk(1'b0, 10);
    pulse(3'b010);
    cyc(1);
    chk(slp, 1'b1);
    rdr(FLAG_OFF);
    chk(v, 32'h5);
    n0 = n_rst;
    tk(1'b0, 31);
    cyc(4);
    chk(n_wk, 0);
    tk(1'b0, 1);
    cyc(3);
    chk(n_wk, 1);
    chk(n_rst - n0, 0);
    chk(slp, 1'b0);
    rdr(FLAG_OFF);
    chk(v, 32'h0);
    rdr(EVT_OFF);
    chk(v, 32'h2);
    cfg <= 2'b10;
    cyc(3);
    pulse(3'b010);
    cyc(2);
    chk(act, 1'b0);
    pulse(3'b100);
    cyc(2);
    chk({slp, act}, 2'b01);
    report_and_stop();
  end

  initial begin
    #900000;
    hang();
  end
endmodule // tb_top
